/* logic/fan_bl_pkg.sv */
// Constants shared by the backlight and fan PWM table controller.
package fan_bl_pkg;
  // Clock and time base.
  localparam int CLK_PERIOD_NS = 32'h0000_0004;
  localparam int NS_PER_S = 32'h3B9A_CA00;
  localparam int MS_NS = 32'h000F_4240;
  localparam int CLK_HZ = NS_PER_S / CLK_PERIOD_NS;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int PHASE_W = 32'h0000_001C;
  localparam logic [PHASE_W-1:0] CLK_HZ_P = PHASE_W'(CLK_HZ);
  localparam logic [PHASE_W-1:0] CYC_PER_PERMILLE = PHASE_W'(CLK_HZ / 32'h0000_03E8);
  // Duty in tenths of a percent.
  localparam int DUTY_W = 32'h0000_000A;
  localparam logic [9:0] DUTY_FULL = 10'h3E8;
  // Multiply-and-shift that approximates a division by one thousand.
  localparam logic [31:0] DIV1000_MUL = 32'h0000_0419;
  localparam int DIV1000_SH = 32'h0000_0014;
  // Descriptor codes.
  localparam int DESC_LSB = 32'h0000_0000;
  localparam int DESC_W = 32'h0000_0004;
  localparam logic [3:0] TYPE_VENDOR = 4'h5;
  localparam logic [3:0] TYPE_BL = 4'h6;
  localparam logic [3:0] TYPE_FAN = 4'h7;
  // Vendor entry.
  localparam int VENDOR_LSB = 32'h0000_0004;
  localparam int VENDOR_W = 32'h0000_0010;
  // Backlight control entry.
  localparam int BL_DISP_LSB = 32'h0000_0004;
  localparam int BL_METH_LSB = 32'h0000_0008;
  localparam int BL_NFREQ_LSB = 32'h0000_000C;
  localparam int BL_ADDR_LSB = 32'h0000_0010;
  localparam int BL_ID_LSB = 32'h0000_0018;
  localparam int BL_RSV_LSB = 32'h0000_0010;
  localparam int BL_RSV_W = 32'h0000_0010;
  localparam logic [1:0] BL_METH_PWM = 2'h0;
  localparam logic [1:0] BL_METH_SMBUS = 2'h1;
  // Backlight frequency entry.
  localparam int FQ_HZ_LSB = 32'h0000_0000;
  localparam int HZ_W = 32'h0000_0012;
  localparam int FQ_MAX_LSB = 32'h0000_0020;
  localparam int FQ_MIN_LSB = 32'h0000_002A;
  localparam int FQ_RSV_LSB = 32'h0000_0034;
  localparam int FQ_RSV_W = 32'h0000_000C;
  // Fan header and fan speed entries.
  localparam int FAN_METH_LSB = 32'h0000_0004;
  localparam logic [3:0] FAN_METH_PWM = 4'h0;
  localparam int FAN_N_LSB = 32'h0000_0008;
  localparam int FAN_N_W = 32'h0000_0003;
  localparam int FAN_HZ_LSB = 32'h0000_000C;
  localparam int FAN_RSV0_LSB = 32'h0000_001E;
  localparam int FAN_RSV0_W = 32'h0000_0002;
  localparam int FAN_UP_LSB = 32'h0000_0020;
  localparam int FAN_DN_LSB = 32'h0000_002C;
  localparam int RAMP_W = 32'h0000_000C;
  localparam int FAN_RSV1_LSB = 32'h0000_0038;
  localparam int FAN_RSV1_W = 32'h0000_0008;
  localparam int SPD_TEMP_LSB = 32'h0000_0000;
  localparam int TEMP_W = 32'h0000_000B;
  localparam int SPD_VAL_LSB = 32'h0000_000B;
endpackage

/* logic/fan_bl_pwm_ctrl.sv */
// Table decoder that drives the backlight and fan PWM outputs.
//
// Contract
// [RULE_01] Descriptor code 0x06 marks a 32-bit backlight control entry.
// [RULE_02] Backlight bits 7:4 give the zero-based index of the affected display.
// [RULE_03] Backlight bits 9:8 choose PWM pin, SMBus controller, or reserved.
// [RULE_04] Backlight bits 15:12 count following frequency entries; at least one.
// [RULE_05] SMBus carries address in 23:16, identifier in 31:24; PWM needs zeros.
// [RULE_06] Frequency entry holds base frequency in 17:0; bits 63:52 are zero.
// [RULE_07] Frequency entry holds max duty 41:32 and min duty 51:42, tenths percent.
// [RULE_08] Before driver load the backlight runs at the first entry's maximum; the code uses the highest maximum over the first BL_SLOTS entries.
// [RULE_09] Brightness maps between lowest and highest duty over all frequency entries; the code uses only the first BL_SLOTS entries.
// [RULE_10] Descriptor code 0x07 is a 64-bit fan header followed by speed entries.
// [RULE_11] Fan header bits 7:4 choose method; zero is PWM, one reserved.
// [RULE_12] Header bits 10:8 count speed entries; bits 29:12 give fan frequency.
// [RULE_13] Lowest speed to full on takes at least header bits 43:32 milliseconds; the code may take up to one millisecond less.
// [RULE_14] Full on to lowest speed takes at least header bits 55:44 milliseconds; the code may take up to one millisecond less.
// [RULE_15] Fan stays fully on from power-on until software sets a speed.
// [RULE_16] Speed entry threshold temperature in bits 10:0, tenths of a degree.
// [RULE_17] Speed entry fan speed in bits 20:11, tenths of a percent.
// [RULE_18] Table supplier expresses a minimum fan speed with threshold zero.
// [RULE_19] Descriptor code 0x05 is a 64-bit vendor entry, identifier in 19:4.
// [RULE_20] Highest threshold not above temperature wins; PWM made from system clock.
module fan_bl_pwm_ctrl #(
  parameter int BL_SLOTS = 4,
  parameter int FAN_SLOTS = 7,
  parameter int MS_CYCLES = fan_bl_pkg::CYC_PER_MS
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Table entry stream.
  input wire logic table_restart,
  input wire logic entry_valid,
  input wire logic [63:0] entry_data,
  // Software controls.
  input wire logic driver_loaded,
  input wire logic [9:0] brightness_level,
  input wire logic fan_sw_ready,
  input wire logic [10:0] temperature,
  // Backlight side.
  output logic bl_pwm,
  output logic [9:0] bl_duty,
  output logic bl_table_valid,
  output logic bl_use_smbus,
  output logic [7:0] bl_smbus_addr,
  output logic [7:0] bl_controller_id,
  output logic [3:0] bl_display_index,
  // Fan side.
  output logic fan_pwm,
  output logic [9:0] fan_duty,
  output logic fan_table_valid,
  // Status.
  output logic [15:0] vendor_identifier,
  output logic vendor_valid,
  output logic table_error
);
  localparam int PW = fan_bl_pkg::PHASE_W;
  localparam int DW = fan_bl_pkg::DUTY_W;
  localparam int HW = fan_bl_pkg::HZ_W;
  localparam int TW = fan_bl_pkg::TEMP_W;
  localparam int RW = fan_bl_pkg::RAMP_W;

  if (BL_SLOTS < 1 || BL_SLOTS > 15 || FAN_SLOTS < 1 || FAN_SLOTS > 7)
  begin : g_bad_slots
    $error("slot counts must fit the entry count fields");
  end
  if (MS_CYCLES < 1 || MS_CYCLES > 262143)
  begin : g_bad_ms
    $error("millisecond divider must fit its 18-bit counter");
  end

  typedef enum logic [1:0] {ST_DESC, ST_BL_FREQ, ST_FAN_SPEED} parse_t;

  typedef struct packed {
    parse_t st;
    logic [3:0] remain;
    logic [3:0] slot;
    logic bl_seen;
    logic bl_skip;
    logic bl_valid;
    logic [1:0] bl_meth;
    logic [3:0] bl_disp;
    logic [7:0] bl_addr;
    logic [7:0] bl_id;
    logic [3:0] bl_n;
    logic [BL_SLOTS-1:0][HW-1:0] fq_hz;
    logic [BL_SLOTS-1:0][DW-1:0] fq_max;
    logic [BL_SLOTS-1:0][DW-1:0] fq_min;
    logic fan_valid;
    logic [HW-1:0] fan_hz;
    logic [RW-1:0] ramp_up;
    logic [RW-1:0] ramp_dn;
    logic [2:0] fan_n;
    logic [FAN_SLOTS-1:0][TW-1:0] spd_temp;
    logic [FAN_SLOTS-1:0][DW-1:0] spd_val;
    logic fan_run;
    logic [15:0] vendor;
    logic vendor_ok;
    logic tbl_err;
    logic [17:0] ms_cnt;
    logic [12:0] credit;
    logic [HW-1:0] bl_hz;
    logic [PW-1:0] bl_phase;
    logic [PW-1:0] fan_phase;
    logic [DW-1:0] bl_duty;
    logic [DW-1:0] fan_duty;
    logic bl_pwm;
    logic fan_pwm;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Lowest minimum and highest maximum over the stored frequency entries.
  function automatic logic [2*DW-1:0] duty_span(input state_t s);
    logic [DW-1:0] lo;
    logic [DW-1:0] hi;
    lo = fan_bl_pkg::DUTY_FULL;
    hi = '0;
    for (int i = 0; i < BL_SLOTS; i++)
    begin
      if (i < int'(s.bl_n))
      begin
        if (s.fq_min[i] < lo)
          lo = s.fq_min[i];
        if (s.fq_max[i] > hi)
          hi = s.fq_max[i];
      end
    end
    if (lo > hi)
      lo = hi;
    return {lo, hi};
  endfunction

  // First frequency entry whose duty range covers the wanted duty.
  function automatic logic [HW-1:0] pick_hz(input state_t s, input logic [DW-1:0] duty);
    logic [HW-1:0] hz;
    logic hit;
    hz = s.fq_hz[0];
    hit = 1'b0;
    for (int i = 0; i < BL_SLOTS; i++)
    begin
      if (!hit && i < int'(s.bl_n) && duty >= s.fq_min[i] && duty <= s.fq_max[i])
      begin
        hz = s.fq_hz[i];
        hit = 1'b1;
      end
    end
    return hz;
  endfunction

  // Speed of the entry with the highest threshold at or below the temperature.
  function automatic logic [DW-1:0] pick_speed(input state_t s, input logic [TW-1:0] t);
    logic [DW-1:0] spd;
    logic [TW-1:0] best;
    logic hit;
    spd = '0;
    best = '0;
    hit = 1'b0;
    for (int i = 0; i < FAN_SLOTS; i++)
    begin
      if (i < int'(s.fan_n) && s.spd_temp[i] <= t && (!hit || s.spd_temp[i] >= best))
      begin
        spd = s.spd_val[i];
        best = s.spd_temp[i];
        hit = 1'b1;
      end
    end
    return spd;
  endfunction

  // Slowest speed found among the fan speed entries.
  function automatic logic [DW-1:0] low_speed(input state_t s);
    logic [DW-1:0] lo;
    lo = fan_bl_pkg::DUTY_FULL;
    for (int i = 0; i < FAN_SLOTS; i++)
    begin
      if (i < int'(s.fan_n) && s.spd_val[i] < lo)
        lo = s.spd_val[i];
    end
    return lo;
  endfunction

  logic [3:0] desc;
  logic [2*DW-1:0] span_w;
  logic [DW-1:0] bl_lo;
  logic [DW-1:0] bl_hi;
  logic [31:0] scaled;
  logic [DW:0] req_sum;
  logic [DW-1:0] req_duty;
  logic [DW-1:0] bl_target;
  logic [DW-1:0] fan_target;
  logic [DW:0] fan_range;
  logic [RW-1:0] ramp_ms;
  logic [12:0] credit_in;
  logic ms_tick;
  logic [PW:0] bl_sum;
  logic [PW:0] fan_sum;

  assign desc = entry_data[fan_bl_pkg::DESC_LSB +: fan_bl_pkg::DESC_W];
  assign span_w = duty_span(s_q);
  assign bl_lo = span_w[2*DW-1:DW];
  assign bl_hi = span_w[DW-1:0];
  // The request scales across the combined duty range; the result is clamped
  // because the shift only approximates a division by one thousand.
  assign scaled = (32'(bl_hi - bl_lo) * 32'(brightness_level) * fan_bl_pkg::DIV1000_MUL)
    >> fan_bl_pkg::DIV1000_SH; // [RULE_09]
  assign req_sum = (DW + 1)'(bl_lo) + (DW + 1)'(scaled[DW-1:0]);
  assign req_duty = (req_sum > (DW + 1)'(bl_hi) || scaled > 32'(bl_hi)) ? bl_hi : req_sum[DW-1:0];
  assign bl_target = driver_loaded ? req_duty : bl_hi; // [RULE_08]
  assign fan_target = s_q.fan_run ? pick_speed(s_q, temperature)
                                  : fan_bl_pkg::DUTY_FULL; // [RULE_15] [RULE_20]
  assign fan_range = (DW + 1)'(fan_bl_pkg::DUTY_FULL) - (DW + 1)'(low_speed(s_q));
  assign ramp_ms = (fan_target > s_q.fan_duty) ? s_q.ramp_up : s_q.ramp_dn; // [RULE_13] [RULE_14]
  assign ms_tick = s_q.ms_cnt == 18'(MS_CYCLES - 1);
  assign credit_in = s_q.credit + (ms_tick ? 13'(fan_range) : 13'h0000);
  assign bl_sum = (PW + 1)'(s_q.bl_phase) + (PW + 1)'(s_q.bl_hz);
  assign fan_sum = (PW + 1)'(s_q.fan_phase) + (PW + 1)'(s_q.fan_hz);

  always_comb
  begin
    s_d = s_q;
    s_d.ms_cnt = ms_tick ? 18'h0_0000 : s_q.ms_cnt + 18'h0_0001;
    if (table_restart)
    begin
      s_d.st = ST_DESC;
      s_d.bl_seen = 1'b0;
      s_d.bl_valid = 1'b0;
      s_d.fan_valid = 1'b0;
      s_d.vendor_ok = 1'b0;
      s_d.tbl_err = 1'b0;
    end
    else if (entry_valid)
    begin
      case (s_q.st)
        ST_DESC:
        begin
          case (desc)
            fan_bl_pkg::TYPE_VENDOR:
            begin
              s_d.vendor = entry_data[fan_bl_pkg::VENDOR_LSB +: fan_bl_pkg::VENDOR_W]; // [RULE_19]
              s_d.vendor_ok = 1'b1;
            end
            fan_bl_pkg::TYPE_BL:
            begin
              // Only the first backlight entry is kept; later ones are skipped whole.
              s_d.bl_skip = s_q.bl_seen; // [RULE_01]
              s_d.st = ST_BL_FREQ;
              s_d.remain = entry_data[fan_bl_pkg::BL_NFREQ_LSB +: 4]; // [RULE_04]
              s_d.slot = '0;
              if (!s_q.bl_seen)
              begin
                s_d.bl_seen = 1'b1;
                s_d.bl_valid = 1'b0;
                s_d.bl_disp = entry_data[fan_bl_pkg::BL_DISP_LSB +: 4]; // [RULE_02]
                s_d.bl_meth = entry_data[fan_bl_pkg::BL_METH_LSB +: 2]; // [RULE_03]
                s_d.bl_addr = entry_data[fan_bl_pkg::BL_ADDR_LSB +: 8]; // [RULE_05]
                s_d.bl_id = entry_data[fan_bl_pkg::BL_ID_LSB +: 8]; // [RULE_05]
                s_d.bl_n = entry_data[fan_bl_pkg::BL_NFREQ_LSB +: 4];
              end
              if (entry_data[fan_bl_pkg::BL_NFREQ_LSB +: 4] == 4'h0)
              begin
                s_d.st = ST_DESC; // [RULE_04]
                s_d.tbl_err = 1'b1;
              end
              if (entry_data[fan_bl_pkg::BL_METH_LSB +: 2] > fan_bl_pkg::BL_METH_SMBUS)
                s_d.tbl_err = 1'b1; // [RULE_03]
              if (entry_data[fan_bl_pkg::BL_METH_LSB +: 2] == fan_bl_pkg::BL_METH_PWM &&
                  entry_data[fan_bl_pkg::BL_RSV_LSB +: fan_bl_pkg::BL_RSV_W] != 16'h0000)
                s_d.tbl_err = 1'b1; // [RULE_05]
            end
            fan_bl_pkg::TYPE_FAN:
            begin
              s_d.fan_valid = 1'b0; // [RULE_10]
              s_d.fan_hz = entry_data[fan_bl_pkg::FAN_HZ_LSB +: HW]; // [RULE_12]
              s_d.ramp_up = entry_data[fan_bl_pkg::FAN_UP_LSB +: RW]; // [RULE_13]
              s_d.ramp_dn = entry_data[fan_bl_pkg::FAN_DN_LSB +: RW]; // [RULE_14]
              s_d.fan_n = entry_data[fan_bl_pkg::FAN_N_LSB +: fan_bl_pkg::FAN_N_W]; // [RULE_12]
              s_d.remain = {1'b0, entry_data[fan_bl_pkg::FAN_N_LSB +: fan_bl_pkg::FAN_N_W]};
              s_d.slot = '0;
              s_d.st = (s_d.fan_n == 3'h0) ? ST_DESC : ST_FAN_SPEED;
              if (s_d.fan_n == 3'h0 ||
                  entry_data[fan_bl_pkg::FAN_METH_LSB +: 4] != fan_bl_pkg::FAN_METH_PWM ||
                  entry_data[fan_bl_pkg::FAN_RSV0_LSB +: fan_bl_pkg::FAN_RSV0_W] != 2'h0 ||
                  entry_data[fan_bl_pkg::FAN_RSV1_LSB +: fan_bl_pkg::FAN_RSV1_W] != 8'h00)
                s_d.tbl_err = 1'b1; // [RULE_11]
            end
            default:
            begin
              s_d.st = ST_DESC;
            end
          endcase
        end
        ST_BL_FREQ:
        begin
          if (!s_q.bl_skip && int'(s_q.slot) < BL_SLOTS)
          begin
            s_d.fq_hz[s_q.slot] = entry_data[fan_bl_pkg::FQ_HZ_LSB +: HW]; // [RULE_06]
            s_d.fq_max[s_q.slot] = entry_data[fan_bl_pkg::FQ_MAX_LSB +: DW]; // [RULE_07]
            s_d.fq_min[s_q.slot] = entry_data[fan_bl_pkg::FQ_MIN_LSB +: DW]; // [RULE_07]
          end
          if (entry_data[fan_bl_pkg::FQ_RSV_LSB +: fan_bl_pkg::FQ_RSV_W] != 12'h000)
            s_d.tbl_err = 1'b1; // [RULE_06]
          s_d.slot = s_q.slot + 4'h1;
          s_d.remain = s_q.remain - 4'h1;
          if (s_q.remain == 4'h1)
          begin
            s_d.st = ST_DESC;
            if (!s_q.bl_skip)
            begin
              s_d.bl_valid = 1'b1;
              if (int'(s_q.bl_n) > BL_SLOTS)
                s_d.bl_n = 4'(BL_SLOTS);
            end
          end
        end
        ST_FAN_SPEED:
        begin
          if (int'(s_q.slot) < FAN_SLOTS)
          begin
            s_d.spd_temp[s_q.slot] = entry_data[fan_bl_pkg::SPD_TEMP_LSB +: TW]; // [RULE_16]
            s_d.spd_val[s_q.slot] = entry_data[fan_bl_pkg::SPD_VAL_LSB +: DW]; // [RULE_17]
          end
          s_d.slot = s_q.slot + 4'h1;
          s_d.remain = s_q.remain - 4'h1;
          if (s_q.remain == 4'h1)
          begin
            s_d.st = ST_DESC;
            s_d.fan_valid = 1'b1;
          end
        end
        default:
        begin
          s_d.st = ST_DESC;
        end
      endcase
    end
    // Software may take over only once a complete fan table is known.
    if (fan_sw_ready && s_q.fan_valid)
      s_d.fan_run = 1'b1; // [RULE_15]
    // Credit grows by the speed range each millisecond and a step costs the ramp
    // time, so crossing the whole range takes no less than the ramp time minus one millisecond.
    if (s_q.fan_duty == fan_target)
      s_d.credit = '0;
    else if (credit_in >= 13'(ramp_ms))
    begin
      s_d.credit = credit_in - 13'(ramp_ms); // [RULE_13] [RULE_14]
      s_d.fan_duty = (fan_target > s_q.fan_duty) ? s_q.fan_duty + 10'h001
                                                 : s_q.fan_duty - 10'h001;
    end
    else
      s_d.credit = credit_in;
    s_d.bl_duty = s_q.bl_valid ? bl_target : '0;
    s_d.bl_hz = pick_hz(s_q, s_q.bl_duty);
    // Phase accumulators give any hertz figure without a divider.
    s_d.bl_phase = (bl_sum >= (PW + 1)'(fan_bl_pkg::CLK_HZ_P)) ?
      PW'(bl_sum - (PW + 1)'(fan_bl_pkg::CLK_HZ_P)) : bl_sum[PW-1:0]; // [RULE_20]
    s_d.fan_phase = (fan_sum >= (PW + 1)'(fan_bl_pkg::CLK_HZ_P)) ?
      PW'(fan_sum - (PW + 1)'(fan_bl_pkg::CLK_HZ_P)) : fan_sum[PW-1:0]; // [RULE_20]
    s_d.bl_pwm = s_q.bl_valid && s_q.bl_meth == fan_bl_pkg::BL_METH_PWM &&
      s_q.bl_phase < PW'(s_q.bl_duty) * fan_bl_pkg::CYC_PER_PERMILLE; // [RULE_03]
    s_d.fan_pwm = s_q.fan_phase < PW'(s_q.fan_duty) * fan_bl_pkg::CYC_PER_PERMILLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.fan_duty <= fan_bl_pkg::DUTY_FULL; // [RULE_15]
    end
    else
      s_q <= s_d;
  end

  assign bl_pwm = s_q.bl_pwm;
  assign bl_duty = s_q.bl_duty;
  assign bl_table_valid = s_q.bl_valid;
  assign bl_use_smbus = s_q.bl_valid && s_q.bl_meth == fan_bl_pkg::BL_METH_SMBUS;
  assign bl_smbus_addr = (s_q.bl_meth == fan_bl_pkg::BL_METH_SMBUS) ? s_q.bl_addr : 8'h00;
  assign bl_controller_id = (s_q.bl_meth == fan_bl_pkg::BL_METH_SMBUS) ? s_q.bl_id : 8'h00;
  assign bl_display_index = s_q.bl_disp;
  assign fan_pwm = s_q.fan_pwm;
  assign fan_duty = s_q.fan_duty;
  assign fan_table_valid = s_q.fan_valid;
  assign vendor_identifier = s_q.vendor;
  assign vendor_valid = s_q.vendor_ok;
  assign table_error = s_q.tbl_err;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  bl_entry_take_a: assert property (entry_valid && !table_restart && s_q.st == ST_DESC &&
    desc == fan_bl_pkg::TYPE_BL && entry_data[15:12] != 4'h0 |=> s_q.st == ST_BL_FREQ && s_q.bl_seen)
    else $error("backlight entry not taken"); // [RULE_01]
  bl_disp_hold_a: assert property (s_q.bl_valid && !table_restart && !entry_valid |=>
    bl_display_index == $past(bl_display_index))
    else $error("display index changed without an entry"); // [RULE_02]
  smbus_pin_a: assert property (s_q.bl_meth == fan_bl_pkg::BL_METH_SMBUS |=> !bl_pwm)
    else $error("backlight pin driven in bus mode"); // [RULE_03]
  fan_hdr_take_a: assert property (entry_valid && !table_restart && s_q.st == ST_DESC &&
    desc == fan_bl_pkg::TYPE_FAN && entry_data[10:8] != 3'h0 |=>
    s_q.st == ST_FAN_SPEED && s_q.remain == {1'b0, $past(entry_data[10:8])})
    else $error("fan header not taken"); // [RULE_10]
  boot_bright_a: assert property (s_q.bl_valid && !driver_loaded |=> bl_duty == $past(bl_hi))
    else $error("boot brightness not at maximum"); // [RULE_08]
  duty_range_a: assert property (s_q.bl_valid && driver_loaded && $stable(s_q.fq_max) |=>
    bl_duty >= $past(bl_lo) && bl_duty <= $past(bl_hi))
    else $error("brightness outside duty range"); // [RULE_09]
  fan_step_a: assert property (fan_duty != $past(fan_duty) |->
    (fan_duty == $past(fan_duty) + 10'h001) || (fan_duty == $past(fan_duty) - 10'h001))
    else $error("fan speed jumped"); // [RULE_13]
  fan_boot_a: assert property (!s_q.fan_run |-> fan_duty == fan_bl_pkg::DUTY_FULL ##1 fan_pwm)
    else $error("fan not fully on before software"); // [RULE_15]
  vendor_take_a: assert property (entry_valid && !table_restart && s_q.st == ST_DESC &&
    desc == fan_bl_pkg::TYPE_VENDOR |=> vendor_valid && vendor_identifier == $past(entry_data[19:4]))
    else $error("vendor identifier not captured"); // [RULE_19]
endmodule

/* test/pwm_sink.sv */
// Behavioural load that measures the high time and the period of a PWM pin.
module pwm_sink (
  // Clock and pin.
  input wire logic sys_clk,
  input wire logic pwm_in,
  // Last complete period seen, and the count of rising edges.
  output int high_cycles,
  output int period_cycles,
  output int edges
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_edges = 0;
  int hi_run = 0;
  int run = 0;
  logic last = 1'b0;
  assign edges = n_edges;
  // A steady high level is a legal load state, so full duty is never flagged.
  always @(posedge sys_clk)
  begin
    if (pwm_in && !last)
    begin
      high_cycles = hi_run;
      period_cycles = run;
      n_edges = n_edges + 1;
      hi_run = 1;
      run = 1;
    end
    else
    begin
      run = run + 1;
      hi_run = hi_run + int'(pwm_in);
    end
    last = pwm_in;
  end
endmodule

/* test/tb_fan_backlight_pwm_table_ctrl.sv */
// Self-checking bench for the backlight and fan table controller.
module tb_fan_backlight_pwm_table_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, table_restart, entry_valid, driver_loaded, fan_sw_ready;
  logic [63:0] entry_data;
  logic [9:0] brightness_level, bl_duty, fan_duty;
  logic [10:0] temperature;
  logic bl_pwm, bl_table_valid, bl_use_smbus, fan_pwm, fan_table_valid, vendor_valid, table_error;
  logic [7:0] bl_smbus_addr, bl_controller_id;
  logic [3:0] bl_display_index;
  logic [15:0] vendor_identifier;
  int fail_count = 0;
  int num_checks = 0;
  int hi_c, per_c, edges;
  int fan_hi, fan_per, fan_edges;
  // PWM frequency 250000 Hz gives a 1000-cycle period; max 800, min 100.
  localparam logic [63:0] FREQ = 64'h0001_9320_0003_D090;
  localparam logic [63:0] BAD_D [0:5] = '{64'h0000_0006, 64'h0000_1206, 64'h0001_1006,
    64'h0000_1006, 64'h0000_0007, 64'h0000_0117};
  localparam logic [63:0] BAD_C [0:5] = '{64'h0, FREQ, FREQ, FREQ | 64'h8000_0000_0000_0000,
    64'h0, 64'h0006_4000};
  fan_bl_pwm_ctrl #(.MS_CYCLES(10)) fan_bl_pwm_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .table_restart(table_restart), .entry_valid(entry_valid), .entry_data(entry_data),
    .driver_loaded(driver_loaded), .brightness_level(brightness_level),
    .fan_sw_ready(fan_sw_ready), .temperature(temperature), .bl_pwm(bl_pwm),
    .bl_duty(bl_duty), .bl_table_valid(bl_table_valid), .bl_use_smbus(bl_use_smbus),
    .bl_smbus_addr(bl_smbus_addr), .bl_controller_id(bl_controller_id),
    .bl_display_index(bl_display_index), .fan_pwm(fan_pwm), .fan_duty(fan_duty),
    .fan_table_valid(fan_table_valid), .vendor_identifier(vendor_identifier),
    .vendor_valid(vendor_valid), .table_error(table_error));
  pwm_sink pwm_sink_i (.sys_clk(sys_clk), .pwm_in(bl_pwm), .high_cycles(hi_c),
    .period_cycles(per_c), .edges(edges));
  pwm_sink fan_sink_i (.sys_clk(sys_clk), .pwm_in(fan_pwm), .high_cycles(fan_hi),
    .period_cycles(fan_per), .edges(fan_edges));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task send(input logic [63:0] d);
    @(negedge sys_clk);
    entry_valid = 1'b1;
    entry_data = d;
  endtask
  task settle(input int n);
    @(negedge sys_clk);
    entry_valid = 1'b0;
    repeat (n) @(negedge sys_clk);
  endtask
  task restart;
    @(negedge sys_clk);
    table_restart = 1'b1;
    @(negedge sys_clk);
    table_restart = 1'b0;
  endtask
  // Two rising edges are needed so the sink has one whole period at the new duty.
  task wait_edges(input logic fan = 1'b0);
    int e, n;
    e = fan ? fan_edges : edges;
    n = 0;
    while ((fan ? fan_edges : edges) < e + 2 && n < 5000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 5000)
    begin
      fail_count++;
      complete_run();
    end
  endtask
  task fan_move(input logic [10:0] t, input logic [9:0] target, input int min_c);
    int n;
    temperature = t;
    n = 0;
    while (fan_duty !== target && n < 20000)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(fan_duty, target);
    check(n >= min_c, 1'b1);
  endtask
  initial
  begin
    {reset_n, table_restart, entry_valid, driver_loaded, fan_sw_ready} = 5'h00;
    entry_data = 64'h0;
    brightness_level = 10'h000;
    temperature = 11'h000;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    check(fan_duty, 10'h3E8);
    @(negedge sys_clk);
    check(fan_pwm, 1'b1);
    $display("test reset done");
    send(64'h0000_0000_000A_BCD5);
    settle(0);
    check({vendor_valid, vendor_identifier}, 17'h1_ABCD);
    $display("test vendor done");
    send(64'h0000_1036);
    send(FREQ);
    settle(3);
    check({bl_table_valid, bl_use_smbus, bl_display_index}, 6'h23);
    check(bl_duty, 10'h320);
    wait_edges();
    check({hi_c, per_c}, {32'h0000_0320, 32'h0000_03E8});
    driver_loaded = 1'b1;
    // Mapping lo + (hi - lo) * level / 1000 over the 100 to 800 range.
    for (int i = 0; i < 3; i++)
    begin
      brightness_level = (i == 0) ? 10'h000 : (i == 1) ? 10'h1F4 : 10'h3E8;
      repeat (3) @(negedge sys_clk);
      check(bl_duty, (i == 0) ? 10'h064 : (i == 1) ? 10'h1C2 : 10'h320);
    end
    wait_edges();
    check(hi_c, 32'h0000_0320);
    $display("test backlight done");
    restart();
    send(64'h5A3C_2106);
    send(FREQ);
    // Second entry: 125000 Hz, max 900, min 50, so the combined range widens both ways.
    send(64'h0000_CB84_0001_E848);
    settle(3);
    check({bl_use_smbus, bl_smbus_addr, bl_controller_id}, 17'h0_3C5A | 17'h1_0000);
    check(bl_duty, 10'h384);
    brightness_level = 10'h000;
    repeat (3) @(negedge sys_clk);
    check(bl_duty, 10'h032);
    $display("test smbus done");
    for (int i = 0; i < 6; i++)
    begin
      restart();
      check(table_error, 1'b0);
      send(BAD_D[i]);
      send(BAD_C[i]);
      settle(1);
      check(table_error, 1'b1);
    end
    $display("test errors done");
    restart();
    // Fan PWM at 250000 Hz keeps the period at 1000 cycles so the sink can measure it.
    send(64'h003E_83E8_3D09_0207);
    send(64'h0006_4000);
    send(64'h0012_C1F4);
    settle(3);
    check({fan_table_valid, fan_duty}, {1'b1, 10'h3E8});
    fan_sw_ready = 1'b1;
    fan_move(11'h258, 10'h258, 4900);
    wait_edges(1'b1);
    check({fan_hi, fan_per}, {32'h0000_0258, 32'h0000_03E8});
    fan_move(11'h064, 10'h0C8, 4900);
    fan_move(11'h1F4, 10'h258, 4900);
    $display("test fan done");
    complete_run();
  end
endmodule
